/* File: inc/smon_pkg.sv */
`default_nettype none
package smon_pkg;

  // bus geometry
  localparam int DATA_W = 32;
  localparam int AHB_ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam int WORD_SHIFT = 2;

  // ahb encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // register indices; byte address is the index times four
  localparam logic [IDX_W-1:0] IDX_FUNCTION_AND_LINK_STATUS = 6'h00;
  localparam logic [IDX_W-1:0] IDX_SOFT_RESET_COMMAND = 6'h14;
  localparam logic [IDX_W-1:0] IDX_CALIBRATION_TRIGGER = 6'h15;
  localparam logic [IDX_W-1:0] IDX_RESET_UNLOCK_KEY = 6'h17;
  localparam logic [IDX_W-1:0] IDX_FUNCTION_SELECT = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_INPUT_ARRANGEMENT_SELECT = 6'h24;

  // field layout
  localparam int KEY_W = 4;
  localparam int KEY_LSB = 0;
  localparam int SOFT_RESET_BIT = 0;
  localparam int CAL_TRIGGER_BIT = 0;
  localparam int FSEL_W = 3;
  localparam int FSEL_LSB = 0;
  localparam int FSEL_AUTO_SEQ_BIT = 2;
  localparam int ACT_W = 2;
  localparam int INP_W = 2;
  localparam int INP_LSB = 0;

  // values
  localparam logic [KEY_W-1:0] UNLOCK_KEYWORD = 4'ha;
  localparam logic [KEY_W-1:0] KEY_RESET = 4'h0;
  localparam logic [FSEL_W-1:0] FSEL_RESET = 3'h0;
  localparam logic [INP_W-1:0] INP_RESET = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // function select codes
  localparam logic [FSEL_W-1:0] FSEL_MANUAL_A = 3'h0;
  localparam logic [FSEL_W-1:0] FSEL_MANUAL_B = 3'h1;
  localparam logic [FSEL_W-1:0] FSEL_RSVD_A = 3'h2;
  localparam logic [FSEL_W-1:0] FSEL_RSVD_B = 3'h3;
  localparam logic [FSEL_W-1:0] FSEL_MANUAL_SEQ_A = 3'h4;
  localparam logic [FSEL_W-1:0] FSEL_MANUAL_SEQ_B = 3'h5;
  localparam logic [FSEL_W-1:0] FSEL_AUTONOMOUS = 3'h6;
  localparam logic [FSEL_W-1:0] FSEL_PRECISION = 3'h7;

  // active function codes
  localparam logic [ACT_W-1:0] ACT_MANUAL = 2'h0;
  localparam logic [ACT_W-1:0] ACT_AUTONOMOUS = 2'h2;
  localparam logic [ACT_W-1:0] ACT_PRECISION = 2'h3;

  // input arrangement codes
  localparam logic [INP_W-1:0] INP_TWO_SE_A = 2'h0;
  localparam logic [INP_W-1:0] INP_ONE_REMOTE_GND = 2'h1;
  localparam logic [INP_W-1:0] INP_ONE_PSEUDO_DIFF = 2'h2;
  localparam logic [INP_W-1:0] INP_TWO_SE_B = 2'h3;

  typedef enum logic [1:0] {
    ARR_TWO_SINGLE,
    ARR_REMOTE_GROUND,
    ARR_PSEUDO_DIFF
  } arrangement_t;

endpackage : smon_pkg
`default_nettype wire

/* File: core/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output follows only when stages two and three agree
module level_sync (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic async_in,
  output logic level_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_out <= stage3;
      end
    end
  end

endmodule : level_sync
`default_nettype wire

/* File: core/sensor_monitor_control_regs.sv */
// Summary of operation
// RULE1 - soft reset write needs keyword 1010b
// RULE2 - key bits 7-4 read zero
// RULE3 - soft reset bit one resets device
// RULE4 - reset/calibration bits 7-1 read zero
// RULE5 - calibration bit one starts offset calibration
// RULE6 - function resets 000b; 000b/001b manual input zero
// RULE7 - host never writes codes 010b, 011b
// RULE8 - 100b/101b manual with auto sequencing
// RULE9 - 110b autonomous monitoring with sequencing
// RULE10 - 111b high precision with sequencing
// RULE11 - status bit 2 shows fast link
// RULE12 - status bits 1-0 report active function
// RULE13 - status read-only, bits 7-3 zero
// RULE14 - arrangement resets 00b; 00b/11b two channels
// RULE15 - 01b single channel, remote ground sense
// RULE16 - 10b single pseudo-differential channel
// RULE17 - arrangement bits 7-2 read zero
// RULE18 - power-up and general call restore defaults
// RULE19 - key survives device reset; host clears
// RULE20 - zero writes no effect; command bits read zero
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sensor_monitor_control_regs (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [smon_pkg::DATA_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [smon_pkg::DATA_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [smon_pkg::DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic fast_link_in,
  input wire logic general_call_reset_in,
  output logic device_reset_out,
  output logic offset_cal_start_out,
  output logic auto_seq_enable_out,
  output logic input_zero_only_out,
  output logic [smon_pkg::ACT_W-1:0] active_function_out,
  output logic two_channel_out,
  output logic remote_ground_sense_out,
  output logic pseudo_diff_out
);
  import smon_pkg::*;

  // status code for a function select value; reserved codes fall back to manual
  function automatic logic [ACT_W-1:0] active_code(input logic [FSEL_W-1:0] f);
    logic [ACT_W-1:0] code;
    code = ACT_MANUAL;
    case (f)
      FSEL_AUTONOMOUS: code = ACT_AUTONOMOUS; // RULE9
      FSEL_PRECISION: code = ACT_PRECISION; // RULE10
      default: code = ACT_MANUAL; // RULE12
    endcase
    return code;
  endfunction : active_code

  function automatic arrangement_t arrangement(input logic [INP_W-1:0] c);
    arrangement_t a;
    a = ARR_TWO_SINGLE;
    case (c)
      INP_ONE_REMOTE_GND: a = ARR_REMOTE_GROUND; // RULE15
      INP_ONE_PSEUDO_DIFF: a = ARR_PSEUDO_DIFF; // RULE16
      default: a = ARR_TWO_SINGLE; // RULE14
    endcase
    return a;
  endfunction : arrangement

  // ---------------- address phase ----------------
  wire logic [AHB_ADDR_W-1:0] addr_low;
  wire logic [IDX_W-1:0] addr_idx;
  wire logic addr_aligned;
  wire logic upper_clear;
  wire logic bus_take;
  wire logic wr_take;
  wire logic rd_take;

  assign addr_low = haddr_in[AHB_ADDR_W-1:0];
  assign addr_idx = addr_low[AHB_ADDR_W-1:WORD_SHIFT];
  assign addr_aligned = (addr_low[WORD_SHIFT-1:0] == '0);
  assign upper_clear = (haddr_in[DATA_W-1:AHB_ADDR_W] == '0);
  // only whole aligned words are taken; anything else is a harmless no-op
  assign bus_take = hsel_in & htrans_in[HTRANS_ACTIVE_BIT] & hready_in
                    & (hsize_in == HSIZE_WORD) & addr_aligned & upper_clear;
  assign wr_take = bus_take & hwrite_in;
  assign rd_take = bus_take & ~hwrite_in;

  wire logic hit_status;
  wire logic hit_soft_reset;
  wire logic hit_cal;
  wire logic hit_key;
  wire logic hit_func;
  wire logic hit_inp;

  assign hit_status = (addr_idx == IDX_FUNCTION_AND_LINK_STATUS);
  assign hit_soft_reset = (addr_idx == IDX_SOFT_RESET_COMMAND);
  assign hit_cal = (addr_idx == IDX_CALIBRATION_TRIGGER);
  assign hit_key = (addr_idx == IDX_RESET_UNLOCK_KEY);
  assign hit_func = (addr_idx == IDX_FUNCTION_SELECT);
  assign hit_inp = (addr_idx == IDX_INPUT_ARRANGEMENT_SELECT);

  // ---------------- data phase write strobes ----------------
  logic wr_soft_reset;
  logic wr_cal;
  logic wr_key;
  logic wr_func;
  logic wr_inp;

  // the status register has no write strobe at all: writes to it vanish
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      wr_soft_reset <= 1'b0;
      wr_cal <= 1'b0;
      wr_key <= 1'b0;
      wr_func <= 1'b0;
      wr_inp <= 1'b0;
    end else begin
      wr_soft_reset <= wr_take & hit_soft_reset;
      wr_cal <= wr_take & hit_cal;
      wr_key <= wr_take & hit_key;
      wr_func <= wr_take & hit_func;
      wr_inp <= wr_take & hit_inp;
    end
  end // RULE13

  // ---------------- stored fields ----------------
  logic [KEY_W-1:0] unlock_keyword;
  logic [FSEL_W-1:0] function_select_field;
  logic [INP_W-1:0] input_arrangement_field;

  wire logic key_open;
  wire logic soft_reset_hit;
  wire logic cal_hit;
  wire logic wipe;

  assign key_open = (unlock_keyword == UNLOCK_KEYWORD); // RULE1
  // a zero in the command bit is simply no command
  assign soft_reset_hit = wr_soft_reset & hwdata_in[SOFT_RESET_BIT] & key_open; // RULE3 RULE20
  assign cal_hit = wr_cal & hwdata_in[CAL_TRIGGER_BIT]; // RULE5 RULE20
  assign wipe = soft_reset_hit | general_call_reset_in; // RULE18

  wire logic [KEY_W-1:0] next_unlock_keyword;
  wire logic [FSEL_W-1:0] next_function_select_field;
  wire logic [INP_W-1:0] next_input_arrangement_field;

  // the key is deliberately spared by the keyed reset, so software must
  // clear it afterwards or the next stray write resets the part again
  assign next_unlock_keyword = general_call_reset_in ? KEY_RESET
                             : wr_key ? hwdata_in[KEY_LSB +: KEY_W]
                             : unlock_keyword; // RULE19 RULE2
  // reserved codes are stored as written; they act as manual mode
  assign next_function_select_field = wipe ? FSEL_RESET
                                    : wr_func ? hwdata_in[FSEL_LSB +: FSEL_W]
                                    : function_select_field; // RULE6 RULE7
  assign next_input_arrangement_field = wipe ? INP_RESET
                                      : wr_inp ? hwdata_in[INP_LSB +: INP_W]
                                      : input_arrangement_field; // RULE14

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      unlock_keyword <= KEY_RESET;
      function_select_field <= FSEL_RESET;
      input_arrangement_field <= INP_RESET;
    end else begin
      unlock_keyword <= next_unlock_keyword;
      function_select_field <= next_function_select_field;
      input_arrangement_field <= next_input_arrangement_field;
    end
  end // RULE18

  // ---------------- link speed flag ----------------
  logic fast_link_flag;

  level_sync u_fast_link_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in(fast_link_in),
    .level_out(fast_link_flag)
  );

  // ---------------- read path ----------------
  // read data is built from next values so a read right behind a write
  // returns what that write left, at the cost of a longer combinational path
  wire logic [ACT_W-1:0] next_active;
  wire logic [DATA_W-1:0] rd_status;
  wire logic [DATA_W-1:0] rd_key;
  wire logic [DATA_W-1:0] rd_func;
  wire logic [DATA_W-1:0] rd_inp;
  wire logic [DATA_W-1:0] next_rdata;

  assign next_active = active_code(next_function_select_field);
  assign rd_status = DATA_W'({fast_link_flag, next_active}); // RULE11 RULE12 RULE13
  assign rd_key = DATA_W'(next_unlock_keyword); // RULE2
  assign rd_func = DATA_W'(next_function_select_field);
  assign rd_inp = DATA_W'(next_input_arrangement_field); // RULE17
  // soft reset, calibration and unmapped words all read zero
  assign next_rdata = !rd_take ? RDATA_ZERO
                    : hit_status ? rd_status
                    : hit_key ? rd_key
                    : hit_func ? rd_func
                    : hit_inp ? rd_inp
                    : RDATA_ZERO; // RULE4 RULE20

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      hrdata_out <= RDATA_ZERO;
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end else begin
      hrdata_out <= next_rdata;
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end
  end

  // ---------------- block controls ----------------
  arrangement_t arr_now;

  assign arr_now = arrangement(input_arrangement_field);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      device_reset_out <= 1'b0;
      offset_cal_start_out <= 1'b0;
    end else begin
      device_reset_out <= wipe; // RULE3
      offset_cal_start_out <= cal_hit; // RULE5
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      auto_seq_enable_out <= 1'b0;
      input_zero_only_out <= 1'b1;
      active_function_out <= ACT_MANUAL;
    end else begin
      auto_seq_enable_out <= function_select_field[FSEL_AUTO_SEQ_BIT]; // RULE8
      input_zero_only_out <= ~function_select_field[FSEL_AUTO_SEQ_BIT]; // RULE6
      active_function_out <= active_code(function_select_field); // RULE12
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      two_channel_out <= 1'b1;
      remote_ground_sense_out <= 1'b0;
      pseudo_diff_out <= 1'b0;
    end else begin
      two_channel_out <= (arr_now == ARR_TWO_SINGLE); // RULE14
      remote_ground_sense_out <= (arr_now == ARR_REMOTE_GROUND); // RULE15
      pseudo_diff_out <= (arr_now == ARR_PSEUDO_DIFF); // RULE16
    end
  end

endmodule : sensor_monitor_control_regs
`default_nettype wire

/* File: dv/smon_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module smon_checker (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic general_call_reset_in,
  input wire logic device_reset_out,
  input wire logic offset_cal_start_out,
  input wire logic auto_seq_enable_out,
  input wire logic input_zero_only_out,
  input wire logic [1:0] active_function_out,
  input wire logic two_channel_out,
  input wire logic remote_ground_sense_out,
  input wire logic pseudo_diff_out
);
  logic take;
  logic cal_wr;
  logic rd_ph;
  logic wr_ph;
  logic [7:0] ph_a;
  assign take = hsel_in && htrans_in[1] && hready_in && hsize_in == 3'h2
                && haddr_in[1:0] == 2'h0 && haddr_in[31:8] == 24'h0;
  assign cal_wr = wr_ph && ph_a == 8'h54 && hwdata_in[0];
  always_ff @(posedge clk_sys_in) begin
    rd_ph <= nrst_in && take && !hwrite_in;
    wr_ph <= nrst_in && take && hwrite_in;
    ph_a <= haddr_in[7:0];
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_read_upper: assert property (rd_ph |-> hrdata_out[31:4] == 28'h0)
    else $error("reserved read bits set");
  a_wo_zero: assert property (rd_ph && ph_a[7:3] == 5'h0a |-> hrdata_out == 32'h0)
    else $error("command register read not zero");
  a_stat_code: assert property (rd_ph && ph_a == 8'h00 |-> hrdata_out[31:3] == 29'h0
    && hrdata_out[1:0] != 2'h1) else $error("status read malformed");
  a_seq_split: assert property (auto_seq_enable_out != input_zero_only_out)
    else $error("sequencing and input zero both or neither");
  a_arr_onehot: assert property ($onehot({two_channel_out, remote_ground_sense_out,
    pseudo_diff_out})) else $error("input arrangement not one-hot");
  a_act_seq: assert property (active_function_out != 2'h0 |-> auto_seq_enable_out)
    else $error("active function without sequencing");
  a_cal_start: assert property (cal_wr |=> offset_cal_start_out)
    else $error("calibration not started");
  a_cal_cause: assert property (offset_cal_start_out |-> $past(cal_wr))
    else $error("calibration started without write of one");
  a_rst_zero: assert property (wr_ph && ph_a == 8'h50 && !hwdata_in[0]
    && !general_call_reset_in |=> !device_reset_out) else $error("reset on zero write");
  a_rst_pulse: assert property (device_reset_out |=> !device_reset_out)
    else $error("reset pulse too long");
  a_gc_clear: assert property (general_call_reset_in |=> ##1 (two_channel_out
    && input_zero_only_out && active_function_out == 2'h0)) else $error("defaults not restored");
endmodule : smon_checker
bind sensor_monitor_control_regs smon_checker u_smon_checker (.*);
`default_nettype wire

/* File: dv/ahb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
  input wire logic clk_sys_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  import smon_pkg::*;
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = HTRANS_IDLE;
    hwrite_out = 1'b0;
    hsize_out = HSIZE_WORD;
    hwdata_out = 32'h0;
  end
  // entered just after a rising edge; waits on hready with no cycle count assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    haddr_out <= a;
    hwrite_out <= w;
    hsize_out <= HSIZE_WORD;
    hwdata_out <= ~hwdata_out;
    @(posedge clk_sys_in);
    while (hready_in !== 1'b1) @(posedge clk_sys_in);
    hsel_out <= 1'b0;
    htrans_out <= HTRANS_IDLE;
    haddr_out <= ~a;
    hwdata_out <= d;
    @(posedge clk_sys_in);
    while (hready_in !== 1'b1) @(posedge clk_sys_in);
    r = hrdata_in;
  endtask : xfer
endmodule : ahb_host_model
`default_nettype wire

/* File: dv/sensor_monitor_control_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_monitor_control_regs_tb;
  import smon_pkg::*;
  logic clk_sys_in;
  logic nrst_in = 1'b0;
  logic fl = 1'b0;
  logic gcr = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int n_dr = 0;
  int n_cal = 0;
  logic [2:0] fc [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  // every mapped word plus one unmapped word, all zero straight after reset
  logic [31:0] ra [7] = '{32'h00, 32'h50, 32'h54, 32'h5c, 32'h70, 32'h90, 32'h40};
  wire logic hsel, hwrite, hready, hresp, dr, cal, aseq, zo, tc, rg, pd;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans, act;
  wire logic [2:0] hsize;
  wire logic [31:0] ctrl = {25'h0, aseq, zo, act, tc, rg, pd};
  ahb_host_model u_ahb_host_model (.clk_sys_in(clk_sys_in), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
  sensor_monitor_control_regs u_sensor_monitor_control_regs (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .fast_link_in(fl),
    .general_call_reset_in(gcr), .device_reset_out(dr), .offset_cal_start_out(cal),
    .auto_seq_enable_out(aseq), .input_zero_only_out(zo), .active_function_out(act),
    .two_channel_out(tc), .remote_ground_sense_out(rg), .pseudo_diff_out(pd));
  function automatic logic [1:0] exp_act(input logic [2:0] f);
    return f == 3'h6 ? 2'h2 : f == 3'h7 ? 2'h3 : 2'h0;
  endfunction : exp_act
  function automatic logic [31:0] ctrl_exp(input logic [2:0] f, input logic [1:0] i);
    return {25'h0, f[2], !f[2], exp_act(f), i == 2'h0 || i == 2'h3, i == 2'h1, i == 2'h2};
  endfunction : ctrl_exp
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_ahb_host_model.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_ahb_host_model.xfer(1'b0, a, 32'h0, r);
    chk("rdata", e, r);
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask : rd
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (dr === 1'b1) n_dr++;
    if (cal === 1'b1) n_cal++;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    logic [1:0] ia;
    void'($urandom(99912));
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("ctrl", ctrl_exp(3'h0, 2'h0), ctrl);
    wr(32'h5c, 32'h0);
    foreach (ra[k]) rd(ra[k], 32'h0);
    // reserved codes 010b and 011b are never put on the bus
    foreach (fc[k]) begin
      ia = 2'(k);
      fl <= 1'(k);
      wr(32'h70, ($urandom() & 32'hffff_fff8) | 32'(fc[k]));
      wr(32'h90, ($urandom() & 32'hffff_fffc) | 32'(ia));
      repeat (6) @(posedge clk_sys_in);
      rd(32'h70, 32'(fc[k]));
      rd(32'h90, 32'(ia));
      rd(32'h00, {29'h0, 1'(k), exp_act(fc[k])});
      chk("ctrl", ctrl_exp(fc[k], ia), ctrl);
    end
    wr(32'h00, 32'hff);
    rd(32'h00, {29'h0, 1'b1, 2'h3});
    // the key's upper bits are never written by the host
    wr(32'h5c, 32'h05);
    rd(32'h5c, 32'h5);
    wr(32'h50, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    chk("resets", 32'h0, n_dr);
    chk("ctrl", ctrl_exp(3'h7, 2'h1), ctrl);
    wr(32'h5c, 32'ha);
    wr(32'h50, 32'hfe);
    repeat (2) @(posedge clk_sys_in);
    chk("resets", 32'h0, n_dr);
    wr(32'h50, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    chk("resets", 32'h1, n_dr);
    chk("ctrl", ctrl_exp(3'h0, 2'h0), ctrl);
    rd(32'h5c, 32'ha);
    wr(32'h5c, 32'h0);
    rd(32'h50, 32'h0);
    wr(32'h54, 32'h0);
    wr(32'h54, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    chk("cals", 32'h1, n_cal);
    rd(32'h54, 32'h0);
    wr(32'h70, 32'h6);
    wr(32'h90, 32'h2);
    // a harmless non-unlock key so the general call has something to clear
    wr(32'h5c, 32'h3);
    gcr <= 1'b1;
    @(posedge clk_sys_in);
    gcr <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk("ctrl", ctrl_exp(3'h0, 2'h0), ctrl);
    chk("resets", 32'h2, n_dr);
    rd(32'h5c, 32'h0);
    tally_and_finish();
  end
endmodule : sensor_monitor_control_regs_tb
`default_nettype wire
